// file: audio_tx_fifo_map.svh
// Contract
// - overrun enable routes overrun flag to interrupt
// - underrun enable routes underrun flag to interrupt
// - dma enable requests dma while almost empty
// - microcontroller build: dma enable reads zero
// - microcontroller build: threshold field reads zero
// - almost-empty enable raises interrupt while almost empty
// - empty enable raises interrupt while fifo empty
// - fifo enable gates playback; control bits reset zero, threshold code resets to 8
// - almost empty when free entries reach threshold
// - write while enabled and full sets overrun
// - sample request while enabled and empty sets underrun
//
// register offsets, field positions, reset values and sizes of the
// transmit fifo control block; pure definitions, no logic.
`ifndef AUDIO_TX_FIFO_MAP_SVH
`define AUDIO_TX_FIFO_MAP_SVH

`define ATF_CTRL_OFS 8'h20
`define ATF_STAT_OFS 8'h24
`define ATF_DATA_OFS 8'h30

`define ATF_CTRL_EN 0
`define ATF_CTRL_EMPTY_IE 1
`define ATF_CTRL_AEMPTY_IE 2
`define ATF_CTRL_DMA_EN 3
`define ATF_CTRL_UNDER_IE 4
`define ATF_CTRL_OVER_IE 5
`define ATF_CTRL_THR_LSB 8
`define ATF_CTRL_THR_MSB 11
`define ATF_CTRL_THR_RESET 4'h8

`define ATF_STAT_EMPTY 0
`define ATF_STAT_AEMPTY 1
`define ATF_STAT_UNDER 2
`define ATF_STAT_OVER 3

`define ATF_THR_ZERO_ENTRIES 6'h10
`define ATF_FIFO_WIDTH 32
`define ATF_FIFO_DEPTH 32
`define ATF_CNT_W 6

`endif

// file: audio_tx_fifo_pkg.sv
// types shared by the transmit fifo control block
// assumes audio_tx_fifo_map.svh for sizes
package audio_tx_fifo_pkg;

  typedef struct packed {
    logic [3:0] thresh;
    logic over_ie;
    logic under_ie;
    logic dma_en;
    logic aempty_ie;
    logic empty_ie;
    logic en;
  } ctrl_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic over_flag;
    logic under_flag;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic dma_req;
    logic [31:0] sample;
    logic sample_valid;
    logic fifo_en;
  } state_t;

endpackage : audio_tx_fifo_pkg

// file: audio_tx_fifo_if.sv
// carrier between the control block and its sample fifo
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface audio_tx_fifo_if #(
  parameter int WIDTH = 32,
  parameter int CNT_W = 6
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [CNT_W-1:0] count;

  modport ctl (output in_valid, output in_data, output out_ready,
               input in_ready, input out_valid, input out_data, input count);
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data, output count);
endinterface : audio_tx_fifo_if
`default_nettype wire

// file: audio_tx_sample_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes DEPTH is a power of two and CNT_W holds DEPTH
`timescale 1ns/100ps
`default_nettype none
module audio_tx_sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int CNT_W = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fifo ports
  audio_tx_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign f.in_ready = (s_r.count != CNT_W'(DEPTH));
  assign f.out_valid = (s_r.count != '0);
  assign f.out_data = s_r.mem[s_r.rd_ptr];
  assign f.count = s_r.count;
  assign push = f.in_valid & f.in_ready;
  assign pop = f.out_ready & f.out_valid;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = f.in_data;
      s_nxt.wr_ptr = s_r.wr_ptr + PW'(1);
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + CNT_W'(1);
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : audio_tx_sample_fifo
`default_nettype wire

// file: audio_tx_fifo_control.sv
// transmit fifo control: wishbone register slave, sample fifo,
// overrun/underrun flags, dma request and interrupt output
// assumes sample_req_i comes from serial logic on clk_i
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`include "audio_tx_fifo_map.svh"
`timescale 1ns/100ps
`default_nettype none
module audio_tx_fifo_control #(
  // 1: system-on-chip build, 0: microcontroller build
  parameter bit SOC_BUILD = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // dma and interrupt
  output logic dma_req_o,
  output logic irq_o,
  // serial audio side
  input wire logic sample_req_i,
  output logic [31:0] sample_o,
  output logic sample_valid_o,
  output logic fifo_en_o
);

  audio_tx_fifo_pkg::state_t s_r;
  audio_tx_fifo_pkg::state_t s_nxt;

  audio_tx_fifo_if #(
    .WIDTH(`ATF_FIFO_WIDTH),
    .CNT_W(`ATF_CNT_W)
  ) fif ();

  audio_tx_sample_fifo #(
    .WIDTH(`ATF_FIFO_WIDTH),
    .DEPTH(`ATF_FIFO_DEPTH),
    .CNT_W(`ATF_CNT_W)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .f(fif.fifo)
  );

  logic req;
  logic wr;
  logic ctrl_hit;
  logic stat_hit;
  logic data_hit;
  logic fifo_empty;
  logic fifo_aempty;
  logic [`ATF_CNT_W-1:0] free_cnt;
  logic [`ATF_CNT_W-1:0] thr_cnt;
  logic over_set;
  logic under_set;
  logic over_clr;
  logic under_clr;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // one request per cycle; ack drops the cycle after it rises
  assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wr = req & wb_we_i;
  assign ctrl_hit = (wb_adr_i == `ATF_CTRL_OFS);
  assign stat_hit = (wb_adr_i == `ATF_STAT_OFS);
  assign data_hit = (wb_adr_i == `ATF_DATA_OFS);

  // fifo conditions
  assign fifo_empty = ~fif.out_valid;
  assign free_cnt = `ATF_CNT_W'(`ATF_FIFO_DEPTH) - fif.count;
  // code zero stands for sixteen entries
  assign thr_cnt = (s_r.ctrl.thresh == 4'h0) ? `ATF_THR_ZERO_ENTRIES
                   : {2'b00, s_r.ctrl.thresh};
  assign fifo_aempty = (free_cnt >= thr_cnt);

  // writes reach the fifo regardless of enable so playback can be
  // preloaded; a full fifo drops the word
  assign fif.in_valid = wr & data_hit;
  assign fif.in_data = wb_dat_i;
  // drain only while playback is enabled
  assign fif.out_ready = sample_req_i & s_r.ctrl.en;

  assign over_set = wr & data_hit & s_r.ctrl.en & ~fif.in_ready;
  assign under_set = sample_req_i & s_r.ctrl.en & fifo_empty;
  assign over_clr = wr & stat_hit & wb_sel_i[0] & wb_dat_i[`ATF_STAT_OVER];
  assign under_clr = wr & stat_hit & wb_sel_i[0] & wb_dat_i[`ATF_STAT_UNDER];

  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`ATF_CTRL_EN] = s_r.ctrl.en;
    ctrl_rd[`ATF_CTRL_EMPTY_IE] = s_r.ctrl.empty_ie;
    ctrl_rd[`ATF_CTRL_AEMPTY_IE] = s_r.ctrl.aempty_ie;
    ctrl_rd[`ATF_CTRL_DMA_EN] = SOC_BUILD & s_r.ctrl.dma_en;
    ctrl_rd[`ATF_CTRL_UNDER_IE] = s_r.ctrl.under_ie;
    ctrl_rd[`ATF_CTRL_OVER_IE] = s_r.ctrl.over_ie;
    // microcontroller build keeps the default threshold internally
    ctrl_rd[`ATF_CTRL_THR_MSB:`ATF_CTRL_THR_LSB] =
      SOC_BUILD ? s_r.ctrl.thresh : 4'h0;
  end

  always_comb begin
    stat_rd = 32'h0000_0000;
    stat_rd[`ATF_STAT_EMPTY] = fifo_empty;
    stat_rd[`ATF_STAT_AEMPTY] = fifo_aempty;
    stat_rd[`ATF_STAT_UNDER] = s_r.under_flag;
    stat_rd[`ATF_STAT_OVER] = s_r.over_flag;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.sample_valid = 1'b0;

    // read data; unmapped and data-port reads return zero
    if (req && !wb_we_i) begin
      if (ctrl_hit) begin
        s_nxt.rdata = ctrl_rd;
      end else if (stat_hit) begin
        s_nxt.rdata = stat_rd;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end

    if (wr && ctrl_hit && wb_sel_i[0]) begin
      s_nxt.ctrl.en = wb_dat_i[`ATF_CTRL_EN];
      s_nxt.ctrl.empty_ie = wb_dat_i[`ATF_CTRL_EMPTY_IE];
      s_nxt.ctrl.aempty_ie = wb_dat_i[`ATF_CTRL_AEMPTY_IE];
      s_nxt.ctrl.dma_en = SOC_BUILD & wb_dat_i[`ATF_CTRL_DMA_EN];
      s_nxt.ctrl.under_ie = wb_dat_i[`ATF_CTRL_UNDER_IE];
      s_nxt.ctrl.over_ie = wb_dat_i[`ATF_CTRL_OVER_IE];
    end
    if (wr && ctrl_hit && wb_sel_i[1] && SOC_BUILD) begin
      s_nxt.ctrl.thresh = wb_dat_i[`ATF_CTRL_THR_MSB:`ATF_CTRL_THR_LSB];
    end

    // set beats a clear landing in the same cycle
    s_nxt.over_flag = (s_r.over_flag & ~over_clr) | over_set;
    s_nxt.under_flag = (s_r.under_flag & ~under_clr) | under_set;

    // a served request presents the word; underrun leaves it invalid
    if (fif.out_ready && fif.out_valid) begin
      s_nxt.sample = fif.out_data;
      s_nxt.sample_valid = 1'b1;
    end

    s_nxt.fifo_en = s_nxt.ctrl.en;
    s_nxt.dma_req = s_r.ctrl.dma_en & fifo_aempty;
    s_nxt.irq = (s_r.ctrl.over_ie & s_r.over_flag)
              | (s_r.ctrl.under_ie & s_r.under_flag)
              | (s_r.ctrl.aempty_ie & fifo_aempty)
              | (s_r.ctrl.empty_ie & fifo_empty);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl.thresh <= `ATF_CTRL_THR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign dma_req_o = s_r.dma_req;
  assign irq_o = s_r.irq;
  assign sample_o = s_r.sample;
  assign sample_valid_o = s_r.sample_valid;
  assign fifo_en_o = s_r.fifo_en;

endmodule : audio_tx_fifo_control
`default_nettype wire

// file: audio_tx_fifo_control_assertions.sv
// port checks for the transmit fifo control block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module audio_tx_fifo_control_assertions #(
  parameter bit SOC_BUILD = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // dma, interrupt, serial side
  input wire logic dma_req_o,
  input wire logic irq_o,
  input wire logic sample_req_i,
  input wire logic [31:0] sample_o,
  input wire logic sample_valid_o,
  input wire logic fifo_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  chk_ack_answer: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack missing or too long");
  chk_en_write: assert property (
    take && wb_we_i && wb_adr_i == 8'h20 && wb_sel_i[0] |=> fifo_en_o == $past(wb_dat_i[0]))
    else $error("enable not written");
  chk_en_hold: assert property (!(take && wb_we_i && wb_adr_i == 8'h20) |=> $stable(fifo_en_o))
    else $error("enable changed without write");
  chk_ctrl_read: assert property (take && !wb_we_i && wb_adr_i == 8'h20 |=>
    wb_dat_o[0] == fifo_en_o && wb_dat_o[7:6] == 2'h0 && wb_dat_o[31:12] == 20'h0)
    else $error("control readback wrong");
  chk_mcu_read: assert property (take && !wb_we_i && wb_adr_i == 8'h20 && !SOC_BUILD |=>
    !wb_dat_o[3] && wb_dat_o[11:8] == 4'h0)
    else $error("reserved field not zero");
  chk_unmapped_read: assert property (take && !wb_we_i && wb_adr_i > 8'h27 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_valid_cause: assert property (sample_valid_o |-> $past(sample_req_i) && $past(fifo_en_o))
    else $error("sample without request");
  chk_off_no_pop: assert property (sample_req_i && !fifo_en_o |=> !sample_valid_o)
    else $error("sample while disabled");
  cover property (sample_valid_o);
  cover property (irq_o);
  cover property (dma_req_o);
endmodule : audio_tx_fifo_control_assertions
bind audio_tx_fifo_control audio_tx_fifo_control_assertions #(.SOC_BUILD(SOC_BUILD)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dma_req_o(dma_req_o), .irq_o(irq_o), .sample_req_i(sample_req_i),
  .sample_o(sample_o), .sample_valid_o(sample_valid_o), .fifo_en_o(fifo_en_o));
`default_nettype wire

// file: audio_tx_serial_model.sv
// serial output side: asks for a sample every other cycle
// assumes it runs on the bus clock
`timescale 1ns/100ps
`default_nettype none
module audio_tx_serial_model (
  // clock, reset, run
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  // request
  output logic sample_req_o
);
  // one-cycle pulses, never back to back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_req_o <= 1'b0;
    end else begin
      sample_req_o <= go_i && !sample_req_o;
    end
  end
endmodule : audio_tx_serial_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the transmit fifo control block
// assumes the serial model as sample requester
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_s, dat_m, smp, rd, rm;
  logic ack, dma, irq, req, vld, en;
  int bad_count = 0;
  int n_tests = 0;
  int k = 0;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  audio_tx_serial_model sm (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sample_req_o(req));
  audio_tx_fifo_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_s),
    .wb_ack_o(ack), .dma_req_o(dma), .irq_o(irq), .sample_req_i(req), .sample_o(smp),
    .sample_valid_o(vld), .fifo_en_o(en));
  // microcontroller build shares the bus, only its read data is used
  audio_tx_fifo_control #(.SOC_BUILD(1'b0)) dut_mcu (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_m), .wb_ack_o(), .dma_req_o(), .irq_o(),
    .sample_req_i(req), .sample_o(), .sample_valid_o(), .fifo_en_o());
  task automatic finish_test;
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    rd = dat_s;
    rm = dat_m;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  always @(posedge clk_i) begin
    if (vld === 1'b1) begin
      cmp(smp, 32'hA0 + k);
      k++;
    end
  end
  task automatic t_reset;
    bus(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'h800);
    cmp(rm, 32'h0);
    bus(1'b0, 8'h24, 32'h0);
    cmp(rd, 32'h3);
    bus(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b1, 8'h20, 32'hFFF);
    bus(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'hF3F);
    cmp(rm, 32'h37);
  endtask : t_reset
  task automatic t_fill;
    // code zero first: sixteen free entries make the fifo almost empty
    bus(1'b1, 8'h20, 32'h00D);
    for (int i = 0; i < 33; i++) begin
      bus(1'b1, 8'h30, 32'hA0 + i);
      if (i == 15) cmp({30'h0, irq, dma}, 32'h3);
      if (i == 16) cmp({30'h0, irq, dma}, 32'h0);
      if (i == 16) bus(1'b1, 8'h20, 32'h80D);
      if (i == 23) cmp({30'h0, irq, dma}, 32'h3);
      if (i == 24) cmp({30'h0, irq, dma}, 32'h0);
    end
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h20, 32'h821);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b0, 8'h24, 32'h0);
    cmp(rd, 32'h8);
    bus(1'b1, 8'h24, 32'h8);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_fill
  task automatic t_drain;
    bus(1'b1, 8'h20, 32'h810);
    go <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmp(32'(k), 32'h0);
    bus(1'b1, 8'h20, 32'h811);
    for (int i = 0; i < 200 && k < 32; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    go <= 1'b0;
    cmp(32'(k), 32'h20);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b0, 8'h24, 32'h0);
    cmp(rd, 32'h7);
    bus(1'b1, 8'h20, 32'h803);
    bus(1'b1, 8'h24, 32'h4);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h20, 32'h801);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_drain
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_fill();
    t_drain();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
